/* File: core/adc_ctl_pkg.sv */
package adc_ctl_pkg;

  // ----------------------------------------------------------------
  // Configuration carried from the control and clock registers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [4:0] channel_select;
    logic       continuous_enable;
    logic       complete_irq_enable;
    logic       mode_ten_bit;
    logic       long_sample_select;
    logic       low_power_config;
    logic       async_clock_enable;
    logic       input_clock_select;
    logic [1:0] clock_divide_select;
  } cfg_t;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_SYNC    = 5'h02,
    ST_WAKE    = 5'h04,
    ST_SAMPLE  = 5'h08,
    ST_CONVERT = 5'h10
  } state_t;

  // ----------------------------------------------------------------
  // Counts and reset values
  // ----------------------------------------------------------------
  localparam int         SAR_BITS      = 10;
  localparam logic [4:0] CHANNEL_OFF   = 5'h1F;
  localparam logic [9:0] SYNC_BUS_CYC  = 10'h003;
  localparam logic [5:0] FIRST_EXTRA   = 6'h02;
  localparam logic [5:0] SUB_8_SHORT   = 6'h10;
  localparam logic [5:0] SUB_8_LONG    = 6'h24;
  localparam logic [5:0] SUB_10_SHORT  = 6'h13;
  localparam logic [5:0] SUB_10_LONG   = 6'h27;
  localparam logic [9:0] SAR_MSB       = 10'h200;
  localparam logic [7:0] RESULT_RESET  = 8'h00;
  localparam logic [7:0] FULL_8        = 8'hFF;

  // Async clock start-up penalty, a longest time so it rounds down.
  localparam int         ASYNC_WAKE_NS = 5000;
  localparam int         CLK_PERIOD_NS = 10;
  localparam logic [9:0] ASYNC_WAKE_CYC = 10'(ASYNC_WAKE_NS / CLK_PERIOD_NS);

endpackage

/* File: core/adc_conversion_control.sv */
// Function
// - Inputs at or beyond a reference saturate to all ones or to zero.
// - Resolution field picks 10 or 8 bits; the approximation is identical.
// - 10-bit result spans both bytes; 8-bit rounded result goes to low byte.
// - Source is async clock, else alternate or bus clock by clock select.
// - Async clock runs only while converting with it; rate set by low power.
// - Selected source is divided by 1, 2, 4 or 8.
// - One input converted at a time, chosen by the channel select field.
// - Control write with channel not all ones starts a conversion.
// - Continuous mode restarts after each transfer until aborted.
// - Transfer sets complete flag; interrupt raised if enable high then.
// - 10-bit high byte read without low byte blocks transfer, no flag, result lost.
// - A blocked transfer starts another conversion unless an abort comes in the same cycle.
// - Control write aborts a conversion and restarts unless channel all ones.
// - Clock config write, reset, or stop without async clock abort too.
// - Abort keeps last result; reset returns results to reset values.
// - Reset or abort enters inactive state at once, clocks and references off.
// - 8-bit short: first 18 converter clocks plus 3 bus, later 16.
// - 8-bit long: first 38 converter clocks plus 3 bus, later 36.
// - 10-bit short: first 21 converter clocks plus 3 bus, later 19.
// - 10-bit long: first 41 converter clocks plus 3 bus, later 39.
// - Complete flag sets at each unblocked conversion end regardless of enable.
// - Alternate clock is at most bus clock rate; software trigger only.
// - Long sample select stretches the sample window by 20 clocks.
module adc_conversion_control (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Configuration and register write strobes
  input  wire adc_ctl_pkg::cfg_t   cfg_i,
  input  wire logic                status_control_wr_i,
  input  wire logic                clock_config_wr_i,
  input  wire logic                stop_mode_i,
  // Result read strobes
  input  wire logic                result_high_rd_i,
  input  wire logic                result_low_rd_i,
  // Clock source ticks
  input  wire logic                alt_clock_tick_i,
  input  wire logic                async_clock_tick_i,
  // Comparator from the analog side
  input  wire logic                analog_above_i,
  // Results and status
  output logic [7:0]               result_high_byte_o,
  output logic [7:0]               result_low_byte_o,
  output logic                     conversion_complete_flag_o,
  output logic                     irq_o,
  // Analog side control
  output logic [4:0]               channel_select_o,
  output logic [9:0]               dac_code_o,
  output logic                     sample_o,
  output logic                     analog_enable_o,
  output logic                     async_clock_run_o,
  output logic                     async_low_power_o
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  // Converter clocks of one conversion, from the timing table.
  function automatic logic [5:0] conv_clocks(input logic ten, input logic long_s,
                                             input logic is_first);
    logic [5:0] base;
    base = ten ? (long_s ? adc_ctl_pkg::SUB_10_LONG : adc_ctl_pkg::SUB_10_SHORT)
               : (long_s ? adc_ctl_pkg::SUB_8_LONG : adc_ctl_pkg::SUB_8_SHORT);
    conv_clocks = is_first ? base + adc_ctl_pkg::FIRST_EXTRA : base;
  endfunction

  // Rounds ten bits to eight, holding full scale at all ones.
  function automatic logic [7:0] round8(input logic [9:0] r);
    round8 = (r[9:2] == adc_ctl_pkg::FULL_8) ? adc_ctl_pkg::FULL_8 : r[9:2] + 8'(r[1]);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  adc_ctl_pkg::state_t state;
  adc_ctl_pkg::state_t next_state;
  logic [9:0]          cnt;
  logic [9:0]          next_cnt;
  logic [2:0]          div_cnt;
  logic                first;
  logic [9:0]          probe;
  logic                read_lock;
  logic                irq_pend;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Stop without the async clock kills the run; with it, work goes on.
  wire stop_abort_w = stop_mode_i & ~cfg_i.async_clock_enable;
  wire abort_w      = status_control_wr_i | clock_config_wr_i | stop_abort_w;
  wire start_w      = status_control_wr_i & ~stop_abort_w
                    & (cfg_i.channel_select != adc_ctl_pkg::CHANNEL_OFF);
  wire active_w     = (state != adc_ctl_pkg::ST_IDLE);

  // The alternate source is at most the bus clock rate, so it cannot be
  // faster than our own clock here; it arrives as a tick instead.
  wire src_tick_w   = cfg_i.async_clock_enable ? async_clock_tick_i
                    : (cfg_i.input_clock_select ? 1'b1 : alt_clock_tick_i);
  wire [2:0] div_mask_w = 3'((4'h1 << cfg_i.clock_divide_select) - 4'h1);
  wire converter_clock_tick_w  = src_tick_w & ((div_cnt & div_mask_w) == div_mask_w);

  // Sample window is total minus the ten approximation steps.
  wire [5:0] sample_len_w = conv_clocks(cfg_i.mode_ten_bit, cfg_i.long_sample_select,
                                        first) - 6'(adc_ctl_pkg::SAR_BITS);

  // Comparator decides the bit under trial; saturation falls out of it.
  wire [9:0] res_w   = analog_above_i ? dac_code_o : (dac_code_o & ~probe);
  wire last_bit_w    = (state == adc_ctl_pkg::ST_CONVERT) & converter_clock_tick_w & probe[0];
  wire blocked_w     = last_bit_w & cfg_i.mode_ten_bit & read_lock;
  wire transfer_w    = last_bit_w & ~blocked_w;
  wire restart_w     = blocked_w | cfg_i.continuous_enable;
  wire flag_clr_w    = status_control_wr_i | result_low_rd_i;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Abort sits above every state so the run stops in the same cycle.
  always_comb begin
    next_state = state;
    next_cnt   = cnt + 10'h001;
    case (state)
      adc_ctl_pkg::ST_IDLE: begin
        next_cnt = 10'h000;
      end
      adc_ctl_pkg::ST_SYNC: begin
        if (cnt == adc_ctl_pkg::SYNC_BUS_CYC - 10'h001) begin
          next_state = cfg_i.async_clock_enable ? adc_ctl_pkg::ST_WAKE
                                                : adc_ctl_pkg::ST_SAMPLE;
          next_cnt   = 10'h000;
        end
      end
      adc_ctl_pkg::ST_WAKE: begin
        if (cnt == adc_ctl_pkg::ASYNC_WAKE_CYC - 10'h001) begin
          next_state = adc_ctl_pkg::ST_SAMPLE;
          next_cnt   = 10'h000;
        end
      end
      adc_ctl_pkg::ST_SAMPLE: begin
        if (!converter_clock_tick_w) begin
          next_cnt = cnt;
        end else if (cnt == 10'(sample_len_w) - 10'h001) begin
          next_state = adc_ctl_pkg::ST_CONVERT;
          next_cnt   = 10'h000;
        end
      end
      adc_ctl_pkg::ST_CONVERT: begin
        next_cnt = 10'h000;
        if (last_bit_w) begin
          next_state = restart_w ? adc_ctl_pkg::ST_SAMPLE : adc_ctl_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = adc_ctl_pkg::ST_IDLE;
        next_cnt   = 10'h000;
      end
    endcase
    if (abort_w) begin
      next_state = start_w ? adc_ctl_pkg::ST_SYNC : adc_ctl_pkg::ST_IDLE;
      next_cnt   = 10'h000;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      state <= adc_ctl_pkg::ST_IDLE;
      cnt   <= 10'h000;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  // Divider restarts whenever the sequencer is idle, so a run started from idle has its first edge aligned.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !active_w) begin
      div_cnt <= 3'h0;
    end else if (src_tick_w) begin
      div_cnt <= div_cnt + 3'h1;
    end
  end

  // First conversion pays the longer window; later ones in a run do not.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      first <= 1'b1;
    end else if (start_w) begin
      first <= 1'b1;
    end else if (last_bit_w) begin
      first <= 1'b0;
    end
  end

  // Channel is taken at the start so one input is used per run.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      channel_select_o <= adc_ctl_pkg::CHANNEL_OFF;
    end else if (start_w) begin
      channel_select_o <= cfg_i.channel_select;
    end
  end

  // Trial code: keep or drop the bit under test, then try the next one.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      dac_code_o <= 10'h000;
      probe      <= 10'h000;
    end else if (next_state == adc_ctl_pkg::ST_CONVERT && state != adc_ctl_pkg::ST_CONVERT) begin
      dac_code_o <= adc_ctl_pkg::SAR_MSB;
      probe      <= adc_ctl_pkg::SAR_MSB;
    end else if (state == adc_ctl_pkg::ST_CONVERT && converter_clock_tick_w) begin
      dac_code_o <= res_w | (probe >> 1);
      probe      <= probe >> 1;
    end
  end

  // ----------------------------------------------------------------
  // Results, flag and interrupt
  // ----------------------------------------------------------------
  // Aborts never touch the results; only a transfer or reset does.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      result_high_byte_o <= adc_ctl_pkg::RESULT_RESET;
      result_low_byte_o  <= adc_ctl_pkg::RESULT_RESET;
    end else if (transfer_w && cfg_i.mode_ten_bit) begin
      result_high_byte_o <= {6'h00, res_w[9:8]};
      result_low_byte_o  <= res_w[7:0];
    end else if (transfer_w) begin
      result_low_byte_o  <= round8(res_w);
    end
  end

  // Set beats clear so a transfer in the clearing cycle is kept.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      conversion_complete_flag_o <= 1'b0;
      irq_pend                   <= 1'b0;
    end else begin
      if (transfer_w) begin
        conversion_complete_flag_o <= 1'b1;
      end else if (flag_clr_w) begin
        conversion_complete_flag_o <= 1'b0;
      end
      if (transfer_w && cfg_i.complete_irq_enable) begin
        irq_pend <= 1'b1;
      end else if (flag_clr_w) begin
        irq_pend <= 1'b0;
      end
    end
  end

  // Split read lock: a high-byte read holds until the low byte is read.
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || result_low_rd_i) begin
      read_lock <= 1'b0;
    end else if (result_high_rd_i && cfg_i.mode_ten_bit) begin
      read_lock <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the analog side
  // ----------------------------------------------------------------
  // Clocks and references are off whenever the sequencer is idle.
  assign analog_enable_o   = active_w;
  assign sample_o          = (state == adc_ctl_pkg::ST_SAMPLE);
  assign async_clock_run_o = active_w & cfg_i.async_clock_enable;
  assign async_low_power_o = cfg_i.low_power_config;
  assign irq_o             = irq_pend;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  abort_to_idle_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (clock_config_wr_i && !start_w) |=> (state == adc_ctl_pkg::ST_IDLE))
    else $error("abort did not stop the sequencer");

  write_starts_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start_w |=> (state == adc_ctl_pkg::ST_SYNC) && (cnt == 10'h000))
    else $error("control write did not start a conversion");

  channel_off_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (status_control_wr_i && !start_w) |=> !analog_enable_o)
    else $error("all-ones channel write left converter running");

  flag_on_end_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    transfer_w |=> conversion_complete_flag_o)
    else $error("complete flag not set after transfer");

  blocked_drop_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (blocked_w && !conversion_complete_flag_o && !abort_w)
      |=> !conversion_complete_flag_o && $stable(result_low_byte_o))
    else $error("blocked result was transferred");

  blocked_restart_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (blocked_w && !abort_w) |=> (state == adc_ctl_pkg::ST_SAMPLE))
    else $error("blocked transfer did not restart");

  round_full_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (transfer_w && !cfg_i.mode_ten_bit && res_w == 10'h3FF)
      |=> (result_low_byte_o == adc_ctl_pkg::FULL_8))
    else $error("full scale did not saturate in 8-bit mode");

  split_result_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    (transfer_w && cfg_i.mode_ten_bit)
      |=> ({result_high_byte_o[1:0], result_low_byte_o} == $past(res_w))
          && (result_high_byte_o[7:2] == 6'h00))
    else $error("10-bit result not split across bytes");

  sync_three_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    ($rose(state == adc_ctl_pkg::ST_SYNC) && !abort_w) ##1 !abort_w ##1 !abort_w
      |=> (state != adc_ctl_pkg::ST_SYNC))
    else $error("bus clock sync phase not three cycles");

  irq_needs_flag_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    irq_o |-> conversion_complete_flag_o)
    else $error("interrupt without complete flag");

  idle_quiet_a: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    $past(abort_w && !start_w) |-> !analog_enable_o && !async_clock_run_o)
    else $error("analog side not off after abort");

endmodule

/* File: testbench/adc_analog_model.sv */
module adc_analog_model (
  // Clock
  input  wire logic       clk_i,
  // Converter side
  input  wire logic [4:0] channel_select_i,
  input  wire logic [9:0] dac_code_i,
  input  wire logic       sample_i,
  input  wire logic       analog_enable_i,
  // Comparator answer
  output logic            analog_above_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Input levels and hold capacitor
  // ----------------------------------------------------------------
  int   level [32];
  int   held = 0;
  logic idle_pat = 1'h0;

  // Levels above 1023 stand for inputs beyond the high reference.
  task automatic set_level(input int ch, input int lvl);
    level[ch] = lvl;
  endtask

  // Only the selected input reaches the hold capacitor while sampling.
  always @(posedge clk_i) begin
    if (sample_i) begin
      held <= level[channel_select_i];
    end
    idle_pat <= ~idle_pat;
  end

  // A powered-down comparator gives no valid answer, so it shows a moving pattern.
  assign analog_above_o = analog_enable_i ? (held >= int'(dac_code_i)) : idle_pat;
endmodule

/* File: testbench/adc_conversion_control_test.sv */
module adc_conversion_control_test;
  timeunit 1ns;
  timeprecision 1ns;

  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  logic              clk = 1'h0;
  logic              rst = 1'h1;
  adc_ctl_pkg::cfg_t cfg = '0;
  logic              sc_wr = 1'h0;
  logic              ck_wr = 1'h0;
  logic              stop = 1'h0;
  logic              rd_hi = 1'h0;
  logic              rd_lo = 1'h0;
  logic              alt_tick = 1'h0;
  logic              asy_tick = 1'h0;
  logic [1:0]        phase = 2'h0;
  logic              above;
  logic [7:0]        res_hi;
  logic [7:0]        res_lo;
  logic              flag;
  logic              irq;
  logic [4:0]        chan;
  logic [9:0]        dac;
  logic              smp;
  logic              aen;
  logic              arun;
  logic              alp;
  logic [7:0]        exp_hi = 8'h00;
  int                error_cnt = 0;
  int                num_checks = 0;
  int                smp_cnt;
  int                run_cnt;

  // Free-running bus clock.
  initial begin
    forever #5 clk = ~clk;
  end

  // Alternate source ticks every third cycle; the async source runs only on request.
  always @(posedge clk) begin
    phase    <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
    alt_tick <= (phase == 2'h0);
    asy_tick <= arun & ~asy_tick;
  end

  adc_conversion_control adc_conversion_control_i (
    .clk_i(clk), .sys_rst_i(rst), .cfg_i(cfg), .status_control_wr_i(sc_wr),
    .clock_config_wr_i(ck_wr), .stop_mode_i(stop), .result_high_rd_i(rd_hi),
    .result_low_rd_i(rd_lo), .alt_clock_tick_i(alt_tick), .async_clock_tick_i(asy_tick),
    .analog_above_i(above), .result_high_byte_o(res_hi), .result_low_byte_o(res_lo),
    .conversion_complete_flag_o(flag), .irq_o(irq), .channel_select_o(chan),
    .dac_code_o(dac), .sample_o(smp), .analog_enable_o(aen), .async_clock_run_o(arun),
    .async_low_power_o(alp));

  adc_analog_model adc_analog_model_i (
    .clk_i(clk), .channel_select_i(chan), .dac_code_i(dac), .sample_i(smp),
    .analog_enable_i(aen), .analog_above_o(above));

  // ----------------------------------------------------------------
  // Shared checks and drivers
  // ----------------------------------------------------------------
  task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_rng(input int got, input int lo, input int hi, input string what);
    num_checks++;
    if (got < lo || got > hi) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask

  // One-cycle strobe: 0 control write, 1 clock write, 2 high read, 3 low read.
  task automatic pulse(input int which);
    @(posedge clk);
    case (which)
      0: sc_wr <= 1'h1;
      1: ck_wr <= 1'h1;
      2: rd_hi <= 1'h1;
      default: rd_lo <= 1'h1;
    endcase
    @(posedge clk);
    {sc_wr, ck_wr, rd_hi, rd_lo} <= 4'h0;
  endtask

  // Bounded wait for the flag, counting sample and async-run cycles on the way.
  task automatic wait_flag(output int n);
    n = 0;
    smp_cnt = 0;
    run_cnt = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
      smp_cnt += int'(smp);
      run_cnt += int'(arun);
    end while (flag !== 1'h1 && n < 1200);
    chk_rng(n, 1, 1199, "flag wait");
  endtask

  // The flag must stay low for the whole span.
  task automatic quiet(input int cycles, input string what);
    int hits;
    hits = 0;
    repeat (cycles) begin
      @(posedge clk);
      #1;
      hits += int'(flag === 1'h1);
    end
    chk_rng(hits, 0, 0, what);
  endtask

  function automatic logic [9:0] expect_res(input int lvl, input logic ten);
    int r;
    r = (lvl > 1023) ? 1023 : lvl;
    if (!ten) r = ((r + 2) / 4 > 255) ? 255 : (r + 2) / 4;
    return 10'(r);
  endfunction

  function automatic adc_ctl_pkg::cfg_t mk(input logic [4:0] ch, input logic ten,
                                           input logic lng, input logic [1:0] dv);
    adc_ctl_pkg::cfg_t c;
    c = '0;
    c.channel_select = ch;
    c.mode_ten_bit = ten;
    c.long_sample_select = lng;
    c.input_clock_select = 1'h1;
    c.clock_divide_select = dv;
    return c;
  endfunction

  task automatic chk_reset();
    chk(10'(res_hi), 10'h000, "high reset");
    chk(10'(res_lo), 10'h000, "low reset");
    chk(10'({flag, irq, aen, arun}), 10'h000, "inactive");
    chk(10'(chan), 10'h01F, "channel reset");
  endtask

  // Start one conversion from a control write and judge value, bytes, flag and time.
  task automatic single(input adc_ctl_pkg::cfg_t c, input int lvl, input int converter_clock,
                        input int per, input int wake);
    int n;
    logic [9:0] r;
    r = expect_res(lvl, c.mode_ten_bit);
    adc_analog_model_i.set_level(int'(c.channel_select), lvl);
    @(posedge clk);
    cfg <= c;
    pulse(0);
    wait_flag(n);
    if (c.mode_ten_bit) exp_hi = {6'h00, r[9:8]};
    chk_rng(n, (converter_clock - 2) * per + wake, converter_clock * per + wake + 5, "time");
    chk(10'(res_lo), 10'(r[7:0]), "low byte");
    chk(10'(res_hi), 10'(exp_hi), "high byte");
    chk(10'(chan), 10'(c.channel_select), "channel");
    chk(10'(irq), 10'(c.complete_irq_enable), "irq");
    chk(10'(run_cnt > 0), 10'(c.async_clock_enable), "async run");
    chk(10'(alp), 10'(c.low_power_config), "low power");
    pulse(3);
    @(posedge clk);
    #1;
    chk(10'({irq, flag}), 10'h000, "flag clear");
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Every resolution and sample length, at divide by one and by eight.
  task automatic t_modes();
    int converter_clock [4] = '{18, 38, 21, 41};
    int s_short;
    s_short = 0;
    for (int d = 0; d < 2; d++) begin
      for (int m = 0; m < 4; m++) begin
        single(mk(5'(m + 3 * d), m[1], m[0], 2'(3 * d)), 200 + 97 * m + 50 * d, converter_clock[m],
               1 + 7 * d, 0);
        if (!m[0]) s_short = smp_cnt;
        else chk_rng(smp_cnt - s_short, 140 * d + 19, 140 * d + 21, "window");
      end
    end
  endtask

  // Full-scale inputs in both resolutions, zero in 10-bit and round-up-to-full in 8-bit.
  task automatic t_sat();
    single(mk(5'h07, 1'h1, 1'h0, 2'h0), 1500, 21, 1, 0);
    single(mk(5'h08, 1'h0, 1'h0, 2'h0), 1500, 18, 1, 0);
    single(mk(5'h09, 1'h1, 1'h0, 2'h0), 0, 21, 1, 0);
    single(mk(5'h0A, 1'h0, 1'h0, 2'h0), 1022, 18, 1, 0);
  endtask

  // Alternate source, then the async source which wins over the select bit.
  task automatic t_src();
    adc_ctl_pkg::cfg_t c;
    c = mk(5'h0B, 1'h1, 1'h0, 2'h0);
    c.input_clock_select = 1'h0;
    c.complete_irq_enable = 1'h1;
    single(c, 345, 21, 3, 0);
    c.async_clock_enable = 1'h1;
    c.input_clock_select = 1'h1;
    c.low_power_config = 1'h1;
    single(c, 678, 21, 2, 500);
  endtask

  // Continuous run restarts by itself until a write with the channel off.
  task automatic t_cont();
    adc_ctl_pkg::cfg_t c;
    int n;
    c = mk(5'h0C, 1'h1, 1'h0, 2'h1);
    c.continuous_enable = 1'h1;
    adc_analog_model_i.set_level(12, 400);
    @(posedge clk);
    cfg <= c;
    pulse(0);
    wait_flag(n);
    chk(10'(res_lo), 10'h090, "first");
    adc_analog_model_i.set_level(12, 555);
    pulse(3);
    wait_flag(n);
    chk_rng(n + 2, 36, 41, "next time");
    chk(10'(res_lo), 10'h02B, "next");
    pulse(3);
    c.channel_select = 5'h1F;
    @(posedge clk);
    cfg <= c;
    pulse(0);
    @(posedge clk);
    #1;
    chk(10'({aen, arun}), 10'h000, "idle");
    quiet(200, "stopped");
    chk(10'(res_lo), 10'h02B, "kept");
  endtask

  // A high read without the low read blocks the transfer and forces a restart.
  task automatic t_block();
    int n;
    single(mk(5'h0D, 1'h1, 1'h0, 2'h3), 123, 21, 8, 0);
    adc_analog_model_i.set_level(13, 777);
    pulse(0);
    repeat (20) @(posedge clk);
    pulse(2);
    quiet(220, "blocked");
    chk(10'(res_lo), 10'h07B, "old low");
    chk(10'(aen), 10'h001, "restarted");
    pulse(3);
    wait_flag(n);
    chk(10'(res_lo), 10'h009, "new low");
    chk(10'(res_hi), 10'h003, "new high");
    pulse(3);
  endtask

  // Aborts by control write, clock write, stop and reset; stop with async runs on.
  task automatic t_abort();
    adc_ctl_pkg::cfg_t c;
    int n;
    c = mk(5'h0E, 1'h1, 1'h1, 2'h3);
    single(c, 256, 41, 8, 0);
    pulse(0);
    repeat (40) @(posedge clk);
    single(c, 600, 41, 8, 0);
    for (int k = 0; k < 2; k++) begin
      pulse(0);
      repeat (40) @(posedge clk);
      if (k == 0) pulse(1);
      else stop <= 1'h1;
      repeat (2) @(posedge clk);
      #1;
      chk(10'(aen), 10'h000, "aborted");
      @(posedge clk);
      stop <= 1'h0;
      quiet(400, "no result");
      chk(10'(res_lo), 10'h058, "kept");
    end
    c.async_clock_enable = 1'h1;
    @(posedge clk);
    cfg <= c;
    pulse(0);
    repeat (40) @(posedge clk);
    stop <= 1'h1;
    wait_flag(n);
    chk(10'(flag), 10'h001, "done in stop");
    @(posedge clk);
    stop <= 1'h0;
    pulse(3);
    pulse(0);
    repeat (40) @(posedge clk);
    rst <= 1'h1;
    @(posedge clk);
    rst <= 1'h0;
    #1;
    chk_reset();
  endtask

  task automatic end_of_test();
    $display("checks %0d, errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence after the reset span.
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    #1;
    chk_reset();
    t_modes();
    t_sat();
    t_src();
    t_cont();
    t_block();
    t_abort();
    end_of_test();
  end

  // The scenarios need under 10000 cycles, so a hang is cut at three times that.
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    end_of_test();
  end
endmodule
